// [hdl/dpc_port_power.sv]
// module: power enable and overcurrent sense for downstream ports 1 to 3 plus split-port USB 3.2 enables
//
// Behaviour
// [RL1] enabled port: pin is input with pull-up, low level means overcurrent
// [RL2] disabled port, by configuration or host: pin driven low as output
// [RL3] split off: combined pin powers both USB 2.0 and USB 3.2 parts
// [RL4] split on: combined pin powers only the USB 2.0 part
// [RL5] split on: active-high USB 3.2 enables driven for ports 3, 4, 5
// [RL6] split off: USB 3.2 enable outputs have no function, held low
// [RL7] system uses USB 3.2 enables only for embedded devices
// [RL8] combined pin may float only when port disabled by configuration
// [RL9] overcurrent input synchronised to the core clock before flagging
`timescale 1ns/10ps
module dpc_port_power #(
  parameter int NUM_PORTS    = dpc_pkg::NUM_COMBINED,
  parameter int NUM_SS_PORTS = dpc_pkg::NUM_SS
) (
  input  wire logic                                       clk,
  input  wire logic                                       rst,
  input  wire logic                                       split_port_option,
  input  wire dpc_pkg::dpc_port_ctrl_s [NUM_PORTS-1:0]    port_ctrl,
  input  wire dpc_pkg::dpc_port_ctrl_s [NUM_SS_PORTS-1:0] ss_ctrl,
  input  wire logic [NUM_PORTS-1:0]                       power_sense_in,
  output dpc_pkg::dpc_pin_drive_s [NUM_PORTS-1:0]         power_sense_drive,
  output logic [NUM_PORTS-1:0]                            overcurrent,
  output logic [NUM_PORTS-1:0]                            ss_follows_combined,
  output logic [NUM_SS_PORTS-1:0]                         ss_power_enable
);
  import dpc_pkg::*;

  // combined pins exist for ports 1 to 3 only, dedicated enables for ports 3 to 5 only
  if (NUM_PORTS < 1 || NUM_PORTS > NUM_COMBINED) begin : g_bad_num_ports
    $error("NUM_PORTS must lie between 1 and NUM_COMBINED");
  end
  if (NUM_SS_PORTS < 1 || NUM_SS_PORTS > NUM_SS) begin : g_bad_num_ss
    $error("NUM_SS_PORTS must lie between 1 and NUM_SS");
  end

  // enable decode
  logic [NUM_PORTS-1:0]           port_on;
  logic [NUM_SS_PORTS-1:0]        ss_on;
  // pin drive group
  dpc_pin_drive_s [NUM_PORTS-1:0] next_drive;
  // pin synchroniser
  logic [NUM_PORTS-1:0]           sense_stage1;
  logic [NUM_PORTS-1:0]           sense_stage2;
  // own drive state delayed in step with the synchroniser
  logic [NUM_PORTS-1:0]           release_age1;
  logic [NUM_PORTS-1:0]           release_age2;
  logic [NUM_PORTS-1:0]           next_release_age1;
  logic [NUM_PORTS-1:0]           next_release_age2;
  // flags and split outputs
  logic [NUM_PORTS-1:0]           next_overcurrent;
  logic [NUM_PORTS-1:0]           next_follow;
  logic [NUM_SS_PORTS-1:0]        next_ss_enable;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      always_comb begin
        port_on[g] = port_ctrl[g].cfg_enable & port_ctrl[g].host_enable;
      end

      always_comb begin
        next_drive[g].out = PIN_DRIVE_LEVEL;
        if (port_on[g]) begin
          // release the pin so the pull-up powers the port (see [RL1])
          next_drive[g].oe = 1'b0;
        end else begin
          // configuration or host has switched the port off (see [RL2])
          next_drive[g].oe = 1'b1;
        end
      end

      // a pin we drove low still reads low for two cycles through the synchroniser,
      // so sensing waits until the release has reached the same stage
      always_comb begin
        next_release_age1[g] = ~power_sense_drive[g].oe;
        next_release_age2[g] = release_age1[g];
      end

      always_comb begin
        if (port_on[g] && !power_sense_drive[g].oe && release_age2[g]) begin
          // live level, not sticky: clears once the monitor lets go (see [RL1]) (see [RL9])
          next_overcurrent[g] = ~sense_stage2[g];
        end else begin
          // masked while the port is off or still driven (see [RL2])
          next_overcurrent[g] = 1'b0;
        end
      end

      always_comb begin
        if (split_port_option) begin
          // combined pin reaches the USB 2.0 part only (see [RL4])
          next_follow[g] = 1'b0;
        end else begin
          // combined pin governs the USB 3.2 part as well (see [RL3])
          next_follow[g] = 1'b1;
        end
      end
    end

    for (g = 0; g < NUM_SS_PORTS; g++) begin : g_ss
      always_comb begin
        ss_on[g] = ss_ctrl[g].cfg_enable & ss_ctrl[g].host_enable;
      end

      always_comb begin
        if (split_port_option) begin
          // dedicated active-high enable for ports 3, 4 and 5 (see [RL5])
          next_ss_enable[g] = ss_on[g];
        end else begin
          // no function without split, held low (see [RL6])
          next_ss_enable[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        power_sense_drive[i].out <= PIN_DRIVE_LEVEL;
        power_sense_drive[i].oe  <= RESET_DRIVE;
      end
    end else begin
      power_sense_drive <= next_drive;
    end
  end

  // pin is asynchronous to clk; two stages before any logic reads it (see [RL9])
  always_ff @(posedge clk) begin
    if (rst) begin
      sense_stage1 <= {NUM_PORTS{RESET_SENSE}};
      sense_stage2 <= {NUM_PORTS{RESET_SENSE}};
    end else begin
      sense_stage1 <= power_sense_in;
      sense_stage2 <= sense_stage1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      release_age1 <= {NUM_PORTS{~RESET_DRIVE}};
      release_age2 <= {NUM_PORTS{~RESET_DRIVE}};
    end else begin
      release_age1 <= next_release_age1;
      release_age2 <= next_release_age2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overcurrent <= {NUM_PORTS{RESET_OC_FLAG}};
    end else begin
      overcurrent <= next_overcurrent;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ss_follows_combined <= {NUM_PORTS{RESET_FOLLOW}};
    end else begin
      ss_follows_combined <= next_follow;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ss_power_enable <= {NUM_SS_PORTS{RESET_SS_ENABLE}};
    end else begin
      ss_power_enable <= next_ss_enable;
    end
  end
endmodule

// [hdl/dpc_pkg.sv]
// package: constants and carrier types for downstream port power control
package dpc_pkg;
  localparam int NUM_COMBINED = 3;
  localparam int NUM_SS       = 3;
  localparam int FIRST_SS_PORT = 3;
  localparam logic RESET_OC_FLAG = 1'b0;
  localparam logic RESET_DRIVE   = 1'b1;
  localparam logic RESET_SENSE     = 1'b1;
  localparam logic RESET_FOLLOW    = 1'b1;
  localparam logic RESET_SS_ENABLE = 1'b0;
  localparam logic PIN_DRIVE_LEVEL = 1'b0;

  // one combined power/sense pin as seen at the design port
  typedef struct packed {
    logic out;
    logic oe;
  } dpc_pin_drive_s;

  // per-port enable request from configuration and host
  typedef struct packed {
    logic cfg_enable;
    logic host_enable;
  } dpc_port_ctrl_s;
endpackage

// [testbench/dpc_port_power_assertions.sv]
// checker: pin drive, overcurrent and split enables
`timescale 1ns/10ps
module dpc_chk
  import dpc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 split_port_option,
  input wire dpc_port_ctrl_s [2:0] port_ctrl,
  input wire dpc_port_ctrl_s [2:0] ss_ctrl,
  input wire logic [2:0]           power_sense_in,
  input wire dpc_pin_drive_s [2:0] power_sense_drive,
  input wire logic [2:0]           overcurrent,
  input wire logic [2:0]           ss_follows_combined,
  input wire logic [2:0]           ss_power_enable
);
  wire [5:0] d  = power_sense_drive;
  wire [5:0] p  = port_ctrl;
  wire [5:0] q  = ss_ctrl;
  wire [2:0] oe = {d[4], d[2], d[0]};
  wire [2:0] en = {&p[5:4], &p[3:2], &p[1:0]};
  wire [2:0] se = {&q[5:4], &q[3:2], &q[1:0]};
  wire       s  = split_port_option;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_OE: assert property (!rst |=> oe == ~$past(en))
    else $error("pin drive does not follow port enable");
  AST_OUT: assert property ((d & 6'h2A) == 6'h00)
    else $error("pin drive level is not low");
  AST_MIX: assert property (!rst |=> ss_follows_combined == {3{!$past(s)}})
    else $error("combined pin scope does not follow split option");
  AST_SSE: assert property (!rst |=> ss_power_enable == ($past(se) & {3{$past(s)}}))
    else $error("dedicated enable does not follow its request");
  AST_SSO: assert property ((!s) [*2] |-> ss_power_enable == 3'h0)
    else $error("dedicated enable active without split");
  AST_OCS: assert property ((en[0] && !oe[0] && !power_sense_in[0]) [*5] |-> overcurrent[0])
    else $error("overcurrent not flagged on port 1");
  AST_OCM: assert property ((!en[1]) [*3] |-> !overcurrent[1])
    else $error("overcurrent flagged on disabled port 2");
  AST_OCY: assert property ($rose(overcurrent[2]) |-> !$past(power_sense_in[2], 3))
    else $error("overcurrent flag raised without synchronised low pin");
  AST_OCR: assert property (overcurrent[1] |-> !$past(oe[1]) && !$past(oe[1], 3))
    else $error("overcurrent flag raised from own drive after release");

  cover property (overcurrent[0]);
  cover property (s && ss_power_enable[2]);
  cover property ($fell(oe[1]));
  cover property (!s && en == 3'h7 && ss_follows_combined == 3'h7);
endmodule

bind dpc_port_power dpc_chk u_chk (
  .clk                 (clk),
  .rst                 (rst),
  .split_port_option   (split_port_option),
  .port_ctrl           (port_ctrl),
  .ss_ctrl             (ss_ctrl),
  .power_sense_in      (power_sense_in),
  .power_sense_drive   (power_sense_drive),
  .overcurrent         (overcurrent),
  .ss_follows_combined (ss_follows_combined),
  .ss_power_enable     (ss_power_enable)
);

// [testbench/dpc_switch_model.sv]
// partner: power switch and current monitor on each combined pin
`timescale 1ns/10ps
// the USB 3.2 enables feed only an embedded device, so no port switch is modelled for them
module dpc_switch_model (
  input  wire logic [2:0] oe,
  input  wire logic [2:0] fault,
  output logic [2:0]      pin
);
  // pull-up unless the hub drives low or the monitor trips
  assign pin = ~(oe | fault);
endmodule

// [testbench/tb_dpc_port_power.sv]
// testbench: random enables, split mode and faults
`timescale 1ns/10ps
module tb_dpc_port_power;
  import dpc_pkg::*;
  logic clk = 0, rst = 1, split_port_option = 0;
  logic [2:0] fault = 0, pin, overcurrent, ss_follows_combined, ss_power_enable;
  dpc_port_ctrl_s [2:0] port_ctrl = '0, ss_ctrl = '0;
  dpc_pin_drive_s [2:0] power_sense_drive;
  wire [2:0] oe = {power_sense_drive[2].oe, power_sense_drive[1].oe, power_sense_drive[0].oe};
  int num_errors = 0, samples_checked = 0, cyc = 0;
  always #25 clk = ~clk;
  dpc_port_power uut (.clk, .rst, .split_port_option, .port_ctrl, .ss_ctrl, .power_sense_in(pin),
    .power_sense_drive, .overcurrent, .ss_follows_combined, .ss_power_enable);
  dpc_switch_model sw (.oe(oe), .fault, .pin);
  function automatic logic [2:0] on(dpc_port_ctrl_s [2:0] c); return {&c[2], &c[1], &c[0]}; endfunction
  task chk(string n, logic [2:0] s, e); samples_checked++;
    if (s !== e) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end endtask
  task test_done; $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish; endtask
  always @(posedge clk) if (++cyc > 1200) begin num_errors++; test_done; end
  initial begin
    void'($urandom(74778));
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 150; i++) begin
      @(posedge clk);
      {port_ctrl, ss_ctrl, split_port_option, fault} <= i == 0 ? 16'hFFFF : i == 1 ? 16'hFFF0 : 16'($urandom);
      repeat (5) @(posedge clk);
      #1 chk("oe", oe, ~on(port_ctrl));
      chk("overcurrent", overcurrent, on(port_ctrl) & fault);
      chk("follow", ss_follows_combined, {3{~split_port_option}});
      chk("ss_enable", ss_power_enable, on(ss_ctrl) & {3{split_port_option}});
    end
    test_done;
  end
endmodule
